// ### hdl/afe_params.svh
// Register offsets, field positions, reset values and decoded codes for the
// converter configuration register bank.
// Assumes a 4-bit register index on a 32-bit classic Wishbone bus.
`ifndef AFE_PARAMS_SVH
`define AFE_PARAMS_SVH

// Register indices; byte address is four times the index
`define AFE_IDX_INPUT_SELECT 4'h0
`define AFE_IDX_INPUT_BIAS 4'h1
`define AFE_IDX_REF_MON 4'h2
`define AFE_IDX_GAIN_RATE 4'h3
`define AFE_IDX_OFC_LOW 4'h4
`define AFE_IDX_OFC_MID 4'h5
`define AFE_IDX_OFC_HIGH 4'h6
`define AFE_IDX_FSC_LOW 4'h7
`define AFE_IDX_FSC_MID 4'h8
`define AFE_IDX_FSC_HIGH 4'h9
`define AFE_IDX_REV_CUR 4'hA
`define AFE_IDX_CUR_ROUTE 4'hB
`define AFE_IDX_PIN_FUNC 4'hC
`define AFE_IDX_PIN_DIR 4'hD
`define AFE_IDX_PIN_LEVEL 4'hE
`define AFE_IDX_STATUS 4'hF

// Reset values
`define AFE_RST_INPUT_SELECT 8'h01
`define AFE_RST_INPUT_BIAS 8'h00
`define AFE_RST_REF_MON 7'h00
`define AFE_RST_GAIN_RATE 7'h00
`define AFE_RST_OFC 24'h000000
`define AFE_RST_REV_CUR 4'h0
`define AFE_RST_CUR_ROUTE 8'hFF
`define AFE_RST_PIN 8'h00

// Field positions
`define AFE_BCS_MSB 7
`define AFE_BCS_LSB 6
`define AFE_SP_MSB 5
`define AFE_SP_LSB 3
`define AFE_SN_MSB 2
`define AFE_SN_LSB 0
`define AFE_VREF_MSB 6
`define AFE_VREF_LSB 5
`define AFE_RSEL_MSB 4
`define AFE_RSEL_LSB 3
`define AFE_MON_MSB 2
`define AFE_MON_LSB 0
`define AFE_PGA_MSB 6
`define AFE_PGA_LSB 4
`define AFE_DOR_MSB 3
`define AFE_DOR_LSB 0
`define AFE_REV_MSB 7
`define AFE_REV_LSB 4
`define AFE_RDYMODE_BIT 3
`define AFE_OSC_BIT 7

// Decoded codes
`define AFE_DOR_MAX_DISTINCT 4'h9
`define AFE_RATE_TOP 4'h9
`define AFE_MON_NORMAL 3'h0
`define AFE_MON_SHORT 3'h1
`define AFE_VREF_OFF 2'h0
`define AFE_VREF_ON 2'h1

`endif

// ### hdl/afe_pkg.sv
// Types shared by the converter configuration register bank.
// Assumes afe_params.svh for the numeric constants.
package afe_pkg;

   typedef enum logic [1:0] {
      AFE_BURN_OFF = 2'h0,
      AFE_BURN_0U5 = 2'h1,
      AFE_BURN_2U = 2'h2,
      AFE_BURN_10U = 2'h3
   } afe_burn_t;

   typedef enum logic [2:0] {
      AFE_MON_NORMAL_M = 3'h0,
      AFE_MON_SHORT_M = 3'h1,
      AFE_MON_FULLSCALE = 3'h2,
      AFE_MON_TEMP = 3'h3,
      AFE_MON_SECOND_EXTERNAL_REFERENCE_Q = 3'h4,
      AFE_MON_FIRST_EXTERNAL_REFERENCE_Q = 3'h5,
      AFE_MON_AVDD_Q = 3'h6,
      AFE_MON_DVDD_Q = 3'h7
   } afe_mon_t;

   typedef enum logic [1:0] {
      AFE_RSEL_EXT0 = 2'h0,
      AFE_RSEL_EXT1 = 2'h1,
      AFE_RSEL_ONBOARD = 2'h2,
      AFE_RSEL_ONBOARD_EXT0 = 2'h3
   } afe_rsel_t;

   // Bus slave states, one-hot
   typedef enum logic [1:0] {
      AFE_BUS_IDLE = 2'b01,
      AFE_BUS_ACK = 2'b10
   } afe_bus_t;

   typedef struct packed {
      afe_bus_t bus;
      logic ack;
      logic [31:0] rdata;
      logic [7:0] in_sel;
      logic [7:0] bias;
      logic [6:0] ref_mon;
      logic [6:0] gain_rate;
      logic [23:0] offset_coefficient;
      logic [23:0] fullscale_coefficient;
      logic [3:0] cur_ctl;
      logic [7:0] cur_route;
      logic [7:0] pin_func;
      logic [7:0] pin_dir;
      logic [7:0] pin_level;
      logic [1:0] osc_sync;
      logic [1:0] start_sync;
      logic [1:0] conv_sync;
      logic [1:0] rdy_sync;
      logic [1:0] sout_sync;
      logic xfer_sync0;
      logic xfer_sync1;
      logic [2:0] pos_sel;
      logic [2:0] neg_sel;
      logic [7:0] bias_en;
      logic [2:0] mon_sel;
      logic [2:0] eff_gain;
      logic [3:0] rate;
      logic [1:0] burn_sel;
      logic [1:0] ref_sel;
      logic ref_power;
      logic rdy_pin;
      logic sout_pin;
   } afe_state_t;

endpackage : afe_pkg

// ### hdl/afe_regbank.sv
// Configuration register bank of a multi-input delta-sigma converter front end.
// Assumes a classic Wishbone master on clk_i and asynchronous analog-side
// status inputs, synchronised here before use except shutdown_cmd_i, which gates reference power directly.
//
// Chosen here: the Wishbone slave port.
`timescale 1ns/10ps
`include "afe_params.svh"

module afe_regbank
   import afe_pkg::*;
#(
   parameter int NUM_INPUTS = 8,
   parameter logic [3:0] REVISION = 4'h5,  // Arbitrary value
   parameter logic [23:0] FSC_TRIM_BASE = 24'h400000,
   parameter logic [23:0] FSC_TRIM_STEP = 24'h000100
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [5:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic ext_osc_i,
   input wire logic start_pin_i,
   input wire logic shutdown_cmd_i,
   input wire logic conv_busy_i,
   input wire logic result_ready_i,
   input wire logic serial_data_i,
   input wire logic serial_xfer_i,
   output logic shared_serial_out_pin_o,
   output logic result_ready_pin_n_o,
   output logic [2:0] positive_input_sel_o,
   output logic [2:0] negative_input_sel_o,
   output logic [7:0] input_bias_bits_o,
   output logic [2:0] system_monitor_sel_o,
   output logic [2:0] gain_sel_o,
   output logic [3:0] output_rate_sel_o,
   output logic [1:0] burnout_current_sel_o,
   output logic [1:0] reference_select_o,
   output logic reference_power_o,
   output logic [23:0] fullscale_coefficient_o,
   output logic [23:0] offset_coefficient_o,
   output logic [2:0] excitation_magnitude_o,
   output logic [7:0] current_source_routing_o,
   output logic [7:0] pin_function_select_o,
   output logic [7:0] pin_direction_o,
   output logic [7:0] pin_level_o
);

   // Only the four- and eight-input variants have a defined bias mask
   if (NUM_INPUTS != 4 && NUM_INPUTS != 8) begin : g_bad_inputs
      $error("NUM_INPUTS must be 4 or 8");
   end

   afe_state_t st_ff;
   afe_state_t nxt_st;

   // Factory full-scale trim for one gain code
   function automatic logic [23:0] fsc_trim(input logic [2:0] g);
      fsc_trim = FSC_TRIM_BASE + FSC_TRIM_STEP * {21'h000000, g};
   endfunction : fsc_trim

   // Byte-lane write merge
   function automatic logic [7:0] lane0(input logic [7:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
      lane0 = s[0] ? d[7:0] : old;
   endfunction : lane0

   ////////////////////////////////////////////////////////////////////////////////
   // Next state

   logic hit;
   logic wr;
   logic [3:0] idx;
   logic in_map;
   logic [7:0] wbyte;
   logic [2:0] new_gain;
   logic mon_active;
   logic [7:0] bias_mask;
   logic [31:0] rd;

   assign idx = wb_adr_i[5:2];
   assign in_map = idx != `AFE_IDX_STATUS || 1'b1;
   assign hit = wb_cyc_i && wb_stb_i && st_ff.bus == AFE_BUS_IDLE;
   assign wr = hit && wb_we_i && wb_sel_i[0];
   assign wbyte = wb_dat_i[7:0];
   assign bias_mask = (NUM_INPUTS == 8) ? 8'hFF : 8'h0F;

   always_comb begin
      nxt_st = st_ff;
      new_gain = st_ff.gain_rate[`AFE_PGA_MSB:`AFE_PGA_LSB];
      rd = 32'h00000000;

      // Two-flop synchronisers on pins from outside the clock domain
      nxt_st.osc_sync = {st_ff.osc_sync[0], ext_osc_i};
      nxt_st.start_sync = {st_ff.start_sync[0], start_pin_i};
      nxt_st.conv_sync = {st_ff.conv_sync[0], conv_busy_i};
      nxt_st.rdy_sync = {st_ff.rdy_sync[0], result_ready_i};
      nxt_st.sout_sync = {st_ff.sout_sync[0], serial_data_i};
      nxt_st.xfer_sync0 = serial_xfer_i;
      nxt_st.xfer_sync1 = st_ff.xfer_sync0;

      unique case (idx)
         `AFE_IDX_INPUT_SELECT: rd[7:0] = st_ff.in_sel;
         `AFE_IDX_INPUT_BIAS: rd[7:0] = st_ff.bias;
         `AFE_IDX_REF_MON: rd[7:0] = {st_ff.osc_sync[1], st_ff.ref_mon};
         `AFE_IDX_GAIN_RATE: rd[7:0] = {1'b0, st_ff.gain_rate};
         `AFE_IDX_OFC_LOW: rd[7:0] = st_ff.offset_coefficient[7:0];
         `AFE_IDX_OFC_MID: rd[7:0] = st_ff.offset_coefficient[15:8];
         `AFE_IDX_OFC_HIGH: rd[7:0] = st_ff.offset_coefficient[23:16];
         `AFE_IDX_FSC_LOW: rd[7:0] = st_ff.fullscale_coefficient[7:0];
         `AFE_IDX_FSC_MID: rd[7:0] = st_ff.fullscale_coefficient[15:8];
         `AFE_IDX_FSC_HIGH: rd[7:0] = st_ff.fullscale_coefficient[23:16];
         `AFE_IDX_REV_CUR: rd[7:0] = {REVISION, st_ff.cur_ctl};
         `AFE_IDX_CUR_ROUTE: rd[7:0] = st_ff.cur_route;
         `AFE_IDX_PIN_FUNC: rd[7:0] = st_ff.pin_func;
         `AFE_IDX_PIN_DIR: rd[7:0] = st_ff.pin_dir;
         `AFE_IDX_PIN_LEVEL: rd[7:0] = st_ff.pin_level;
         `AFE_IDX_STATUS: rd[7:0] = {1'b0, st_ff.ref_power, st_ff.eff_gain,
                                     st_ff.mon_sel};
      endcase

      unique case (st_ff.bus)
         AFE_BUS_IDLE: begin
            if (hit) begin
               nxt_st.bus = AFE_BUS_ACK;
               nxt_st.ack = 1'b1;
               nxt_st.rdata = wb_we_i ? 32'h00000000 : rd;
            end
         end
         AFE_BUS_ACK: begin
            nxt_st.bus = AFE_BUS_IDLE;
            nxt_st.ack = 1'b0;
            nxt_st.rdata = 32'h00000000;
         end
      endcase

      if (wr && in_map) begin
         unique case (idx)
            `AFE_IDX_INPUT_SELECT: nxt_st.in_sel = lane0(st_ff.in_sel, wb_dat_i, wb_sel_i);
            `AFE_IDX_INPUT_BIAS: nxt_st.bias = wbyte & bias_mask;
            `AFE_IDX_REF_MON: nxt_st.ref_mon = wbyte[6:0];
            `AFE_IDX_GAIN_RATE: begin
               nxt_st.gain_rate = wbyte[6:0];
               new_gain = wbyte[`AFE_PGA_MSB:`AFE_PGA_LSB];
            end
            `AFE_IDX_OFC_LOW: nxt_st.offset_coefficient[7:0] = wbyte;
            `AFE_IDX_OFC_MID: nxt_st.offset_coefficient[15:8] = wbyte;
            `AFE_IDX_OFC_HIGH: nxt_st.offset_coefficient[23:16] = wbyte;
            `AFE_IDX_FSC_LOW: nxt_st.fullscale_coefficient[7:0] = wbyte;
            `AFE_IDX_FSC_MID: nxt_st.fullscale_coefficient[15:8] = wbyte;
            `AFE_IDX_FSC_HIGH: nxt_st.fullscale_coefficient[23:16] = wbyte;
            `AFE_IDX_REV_CUR: nxt_st.cur_ctl = wbyte[3:0];
            `AFE_IDX_CUR_ROUTE: nxt_st.cur_route = wbyte;
            `AFE_IDX_PIN_FUNC: nxt_st.pin_func = wbyte;
            `AFE_IDX_PIN_DIR: nxt_st.pin_dir = wbyte;
            `AFE_IDX_PIN_LEVEL: nxt_st.pin_level = wbyte;
            `AFE_IDX_STATUS: nxt_st.pin_level = st_ff.pin_level;
         endcase
      end

      // A new gain code replaces the coefficient with its factory trim
      if (new_gain != st_ff.gain_rate[`AFE_PGA_MSB:`AFE_PGA_LSB]) begin
         nxt_st.fullscale_coefficient = fsc_trim(new_gain);
      end

      // Derived connections seen by the analog side
      mon_active = st_ff.ref_mon[`AFE_MON_MSB:`AFE_MON_LSB] != `AFE_MON_NORMAL;
      nxt_st.mon_sel = st_ff.ref_mon[`AFE_MON_MSB:`AFE_MON_LSB];
      nxt_st.pos_sel = st_ff.in_sel[`AFE_SP_MSB:`AFE_SP_LSB];
      nxt_st.neg_sel = st_ff.in_sel[`AFE_SN_MSB:`AFE_SN_LSB];
      nxt_st.bias_en = mon_active ? 8'h00 : (st_ff.bias & bias_mask);
      nxt_st.burn_sel = st_ff.in_sel[`AFE_BCS_MSB:`AFE_BCS_LSB];
      nxt_st.ref_sel = st_ff.ref_mon[`AFE_RSEL_MSB:`AFE_RSEL_LSB];
      nxt_st.rate = st_ff.gain_rate[`AFE_DOR_MSB:`AFE_DOR_LSB] > `AFE_DOR_MAX_DISTINCT
                    ? `AFE_RATE_TOP : st_ff.gain_rate[`AFE_DOR_MSB:`AFE_DOR_LSB];
      // Monitor codes past the short-circuit test run at unity gain
      nxt_st.eff_gain = (st_ff.ref_mon[`AFE_MON_MSB:`AFE_MON_LSB] > `AFE_MON_SHORT)
                        ? 3'h0 : st_ff.gain_rate[`AFE_PGA_MSB:`AFE_PGA_LSB];

      unique case (st_ff.ref_mon[`AFE_VREF_MSB:`AFE_VREF_LSB])
         `AFE_VREF_OFF: nxt_st.ref_power = 1'b0;
         `AFE_VREF_ON: nxt_st.ref_power = 1'b1;
         default: nxt_st.ref_power = st_ff.conv_sync[1] && st_ff.start_sync[1]
                                     && !shutdown_cmd_i;
      endcase

      // Ready low on the dedicated pin in every mode; shared pin only when enabled
      nxt_st.rdy_pin = !st_ff.rdy_sync[1];
      nxt_st.sout_pin = (st_ff.cur_ctl[`AFE_RDYMODE_BIT] && !st_ff.xfer_sync1)
                        ? !st_ff.rdy_sync[1] : st_ff.sout_sync[1];
   end

   ////////////////////////////////////////////////////////////////////////////////
   // State register

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_ff <= '0;
         st_ff.bus <= AFE_BUS_IDLE;
         st_ff.in_sel <= `AFE_RST_INPUT_SELECT;
         st_ff.bias <= `AFE_RST_INPUT_BIAS;
         st_ff.ref_mon <= `AFE_RST_REF_MON;
         st_ff.gain_rate <= `AFE_RST_GAIN_RATE;
         st_ff.offset_coefficient <= `AFE_RST_OFC;
         st_ff.fullscale_coefficient <= FSC_TRIM_BASE;
         st_ff.cur_ctl <= `AFE_RST_REV_CUR;
         st_ff.cur_route <= `AFE_RST_CUR_ROUTE;
         st_ff.pin_func <= `AFE_RST_PIN;
         st_ff.pin_dir <= `AFE_RST_PIN;
         st_ff.pin_level <= `AFE_RST_PIN;
         st_ff.neg_sel <= 3'h1;
         st_ff.rdy_pin <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs, all from flip-flops

   assign wb_dat_o = st_ff.rdata;
   assign wb_ack_o = st_ff.ack;
   assign shared_serial_out_pin_o = st_ff.sout_pin;
   assign result_ready_pin_n_o = st_ff.rdy_pin;
   assign positive_input_sel_o = st_ff.pos_sel;
   assign negative_input_sel_o = st_ff.neg_sel;
   assign input_bias_bits_o = st_ff.bias_en;
   assign system_monitor_sel_o = st_ff.mon_sel;
   assign gain_sel_o = st_ff.eff_gain;
   assign output_rate_sel_o = st_ff.rate;
   assign burnout_current_sel_o = st_ff.burn_sel;
   assign reference_select_o = st_ff.ref_sel;
   assign reference_power_o = st_ff.ref_power;
   assign fullscale_coefficient_o = st_ff.fullscale_coefficient;
   assign offset_coefficient_o = st_ff.offset_coefficient;
   assign excitation_magnitude_o = st_ff.cur_ctl[2:0];
   assign current_source_routing_o = st_ff.cur_route;
   assign pin_function_select_o = st_ff.pin_func;
   assign pin_direction_o = st_ff.pin_dir;
   assign pin_level_o = st_ff.pin_level;

endmodule : afe_regbank

// ### tb/afe_regbank_bench.sv
// Self-checking bench for the converter configuration register bank.
// Assumes the checker is bound in; drives Wishbone and status pins directly.
`timescale 1ns/10ps
module afe_regbank_bench;
   localparam logic [3:0] REV = 4'h6; // Arbitrary value
   localparam logic [23:0] BASE = 24'h400000;
   localparam logic [23:0] STEP = 24'h000100;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
   logic [5:0] adr = 6'h00;
   logic [31:0] di = 32'h0, dq;
   logic osc = 1'b0, stp = 1'b0, sd = 1'b0, busy = 1'b0;
   logic rr = 1'b0, sdat = 1'b0, sx = 1'b0;
   logic sout, rdy_n, rpow;
   logic [2:0] pos, neg, mon, gain;
   logic [7:0] bias, q;
   logic [3:0] rate;
   logic [1:0] burn, rsel;
   logic [23:0] fullscale_coefficient, offset_coefficient;
   logic [7:0] route, pfun, pdir, plev;
   logic [2:0] imag;
   int failures = 0, checked = 0, cycles = 0;
   afe_regbank #(.REVISION(REV), .FSC_TRIM_BASE(BASE), .FSC_TRIM_STEP(STEP)) dut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(di), .wb_dat_o(dq), .wb_ack_o(ack),
      .ext_osc_i(osc), .start_pin_i(stp), .shutdown_cmd_i(sd), .conv_busy_i(busy),
      .result_ready_i(rr), .serial_data_i(sdat), .serial_xfer_i(sx),
      .shared_serial_out_pin_o(sout), .result_ready_pin_n_o(rdy_n),
      .positive_input_sel_o(pos), .negative_input_sel_o(neg), .input_bias_bits_o(bias),
      .system_monitor_sel_o(mon), .gain_sel_o(gain), .output_rate_sel_o(rate),
      .burnout_current_sel_o(burn), .reference_select_o(rsel), .reference_power_o(rpow),
      .fullscale_coefficient_o(fullscale_coefficient), .offset_coefficient_o(offset_coefficient),
      .excitation_magnitude_o(imag), .current_source_routing_o(route),
      .pin_function_select_o(pfun), .pin_direction_o(pdir), .pin_level_o(plev)
   );
   always #5 clk_i = ~clk_i;
   ////////////////////////////////////////////////////////////////////////////
   task automatic stop_test();
      if (failures == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : stop_test
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         failures++;
         stop_test();
      end
   end
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   // One classic cycle, then four idle edges so derived and synced outputs settle
   // The wait has no limit of its own; the cycle ceiling ends a hung bus
   task automatic wb(input logic w, input logic [3:0] ix, input logic [7:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {ix, 2'b00};
      di <= {24'h0, d};
      do begin
         @(posedge clk_i);
      end while (ack !== 1'b1);
      q = dq[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      repeat (4) @(posedge clk_i);
      #1;
   endtask : wb
   task automatic wait4();
      repeat (4) @(posedge clk_i);
      #1;
   endtask : wait4
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      logic [3:0] ix [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'hA, 4'hB};
      logic [7:0] rv [6] = '{8'h01, 8'h00, 8'h00, 8'h00, {REV, 4'h0}, 8'hFF};
      for (int i = 0; i < 6; i++) begin
         wb(1'b0, ix[i], 8'h00);
         chk("reset value", rv[i], q);
      end
      chk("negative", 32'h1, neg);
      chk("fullscale", BASE, fullscale_coefficient);
      chk("ready pin", 32'h1, rdy_n);
      chk("routing", 32'hFF, route);
   endtask : t_reset
   task automatic t_map();
      wb(1'b1, 4'h4, 8'h11);
      wb(1'b1, 4'h5, 8'h22);
      wb(1'b1, 4'h6, 8'h33);
      chk("offset", 32'h332211, offset_coefficient);
      wb(1'b1, 4'hB, 8'h5A);
      wb(1'b1, 4'hC, 8'hA5);
      wb(1'b1, 4'hD, 8'h3C);
      wb(1'b1, 4'hE, 8'hC3);
      chk("routing", 32'h5A, route);
      chk("pin function", 32'hA5, pfun);
      chk("pin direction", 32'h3C, pdir);
      chk("pin level", 32'hC3, plev);
      wb(1'b1, 4'hF, 8'hFF);
      chk("pin level", 32'hC3, plev);
   endtask : t_map
   task automatic t_mux();
      for (int b = 0; b < 4; b++) begin
         wb(1'b1, 4'h0, {2'(b), 3'(7 - b), 3'(b + 4)});
         chk("burnout", b, burn);
         chk("positive", 7 - b, pos);
         chk("negative", b + 4, neg);
      end
   endtask : t_mux
   task automatic t_ro();
      @(posedge clk_i);
      osc <= 1'b1;
      wb(1'b1, 4'h2, 8'h00);
      wb(1'b0, 4'h2, 8'h00);
      chk("osc flag", 8'h80, q);
      @(posedge clk_i);
      osc <= 1'b0;
      wb(1'b1, 4'h2, 8'h80);
      wb(1'b0, 4'h2, 8'h00);
      chk("osc flag", 8'h00, q);
      wb(1'b1, 4'hA, 8'hF8);
      wb(1'b0, 4'hA, 8'h00);
      chk("revision", {REV, 4'h8}, q);
   endtask : t_ro
   task automatic t_mon();
      wb(1'b1, 4'h3, 8'h30);
      wb(1'b1, 4'h1, 8'hFF);
      chk("bias", 8'hFF, bias);
      // Counting down ends on normal, which must give the programmed gain back
      for (int m = 7; m >= 0; m--) begin
         wb(1'b1, 4'h2, {5'h00, 3'(m)});
         chk("monitor", m, mon);
         chk("gain", m >= 2 ? 0 : 3, gain);
         chk("bias", m != 0 ? 0 : 8'hFF, bias);
      end
      wb(1'b0, 4'hF, 8'h00);
      chk("status", 8'h18, q);
   endtask : t_mon
   task automatic t_gain();
      for (int g = 0; g < 8; g++) begin
         wb(1'b1, 4'h7, 8'hAA);
         wb(1'b1, 4'h3, {1'b0, 3'(g), 4'(g + 8)});
         chk("gain", g, gain);
         chk("rate", g == 0 ? 8 : 9, rate);
         chk("fullscale", BASE + STEP * g, fullscale_coefficient);
      end
      for (int r = 0; r < 8; r++) begin
         wb(1'b1, 4'h3, {4'h7, 4'(r)});
         chk("rate", r, rate);
      end
   endtask : t_gain
   task automatic t_ref();
      @(posedge clk_i);
      busy <= 1'b1;
      stp <= 1'b1;
      for (int v = 0; v < 4; v++) begin
         wb(1'b1, 4'h2, {1'b0, 2'(v), 2'(v), 3'h0});
         chk("ref select", v, rsel);
         chk("ref power", v != 0, rpow);
      end
      // Reference is powered here, so the current sources may be set
      wb(1'b1, 4'hA, 8'h03);
      chk("magnitude", 32'h3, imag);
      @(posedge clk_i);
      sd <= 1'b1;
      wait4();
      chk("ref power", 32'h0, rpow);
      @(posedge clk_i);
      sd <= 1'b0;
      stp <= 1'b0;
      wait4();
      chk("ref power", 32'h0, rpow);
   endtask : t_ref
   task automatic t_rdy();
      @(posedge clk_i);
      rr <= 1'b1;
      sdat <= 1'b1;
      wb(1'b1, 4'hA, 8'h00);
      chk("ready pin", 32'h0, rdy_n);
      chk("shared pin", 32'h1, sout);
      wb(1'b1, 4'hA, 8'h08);
      chk("ready pin", 32'h0, rdy_n);
      chk("shared pin", 32'h0, sout);
      @(posedge clk_i);
      sx <= 1'b1;
      wait4();
      chk("shared pin", 32'h1, sout);
      @(posedge clk_i);
      rr <= 1'b0;
      sx <= 1'b0;
      sdat <= 1'b0;
      wait4();
      chk("ready pin", 32'h1, rdy_n);
      chk("shared pin", 32'h1, sout);
   endtask : t_rdy
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_mux();
      t_map();
      t_ro();
      t_mon();
      t_gain();
      t_ref();
      t_rdy();
      stop_test();
   end
endmodule : afe_regbank_bench

// ### tb/afe_regbank_sva.sv
// Port checks for the converter configuration register bank.
// Assumes a bind onto afe_regbank: one clock, synchronous active-high reset.
`timescale 1ns/10ps
module afe_regbank_sva #(
   parameter logic [3:0] REVISION = 4'h5
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [5:0] wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic result_ready_i,
   input wire logic result_ready_pin_n_o,
   input wire logic [7:0] input_bias_bits_o,
   input wire logic [2:0] system_monitor_sel_o,
   input wire logic [2:0] gain_sel_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   ////////////////////////////////////////////////////////////////////////////
   ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not acked in the next cycle");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data not zero outside ack");
   rev_read_a: assert property (
      wb_ack_o && !wb_we_i && wb_adr_i[5:2] == 4'hA |-> wb_dat_o[7:4] == REVISION)
      else $error("revision nibble wrong");
   // Five samples cover the two sync flops plus the output register
   rdy_low_a: assert property (result_ready_i [*5] |=> !result_ready_pin_n_o)
      else $error("ready pin not low");
   rdy_high_a: assert property (!result_ready_i [*5] |=> result_ready_pin_n_o)
      else $error("ready pin not high");
   mon_gain_a: assert property (system_monitor_sel_o >= 3'h2 |-> gain_sel_o == 3'h0)
      else $error("gain not forced to one");
   mon_bias_a: assert property (
      system_monitor_sel_o != 3'h0 |-> input_bias_bits_o == 8'h00)
      else $error("bias not overridden by monitor");
endmodule : afe_regbank_sva
////////////////////////////////////////////////////////////////////////////////
bind afe_regbank afe_regbank_sva #(.REVISION(REVISION)) u_sva (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .result_ready_i(result_ready_i), .result_ready_pin_n_o(result_ready_pin_n_o),
   .input_bias_bits_o(input_bias_bits_o), .system_monitor_sel_o(system_monitor_sel_o),
   .gain_sel_o(gain_sel_o)
);
